// file: ppo_pkg.sv
// shared constants and types for the port pin override and port a block
`default_nettype none
package ppo_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_SENSE = 8'h00;
  localparam logic [7:0] IDX_DIR = 8'h01;
  localparam logic [7:0] IDX_LATCH = 8'h02;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h03;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h04;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [7:0] RST_IRQ_STAT = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;

  // ---------------------------------------------------------------
  // bus answers and field positions
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STRB_LANE0 = 0;
  localparam int PCH_H_FIRST = 16;
  localparam int PCH_J_FIRST = 24;

  // per-pin alternate function override bundle
  typedef struct packed {
    logic pullup_override_enable;
    logic direction_override_enable;
    logic output_value_override_enable;
    logic input_buffer_override_enable;
    logic input_buffer_override_value;
  } ppo_ovr_t;

  // one-hot bus channel states
  typedef enum logic [1:0] {
    PPO_WR_IDLE = 2'b01,
    PPO_WR_RESP = 2'b10
  } ppo_wr_state_t;

  typedef enum logic [1:0] {
    PPO_RD_IDLE = 2'b01,
    PPO_RD_RESP = 2'b10
  } ppo_rd_state_t;
endpackage
`default_nettype wire

// file: ppo_change_override.sv
// override logic for pins whose only alternate function is pin-change irq
`default_nettype none
module ppo_change_override #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  input wire logic [W-1:0] i_mask,
  input wire logic i_group_en,
  output ppo_pkg::ppo_ovr_t [W-1:0] o_ovr,
  output logic [W-1:0] o_src
);
  // ---------------------------------------------------------------
  // per-pin override and source routing
  // ---------------------------------------------------------------
  for (genvar g = 0; g < W; g++) begin : g_pin
    // pull-up, direction and value are never taken over
    assign o_ovr[g].pullup_override_enable = 1'b0;
    assign o_ovr[g].direction_override_enable = 1'b0;
    assign o_ovr[g].output_value_override_enable = 1'b0;
    // input buffer kept on only while the pin can raise a change
    assign o_ovr[g].input_buffer_override_enable = i_mask[g] & i_group_en;
    assign o_ovr[g].input_buffer_override_value = 1'b0;
    // each pin feeds its own change source
    assign o_src[g] = i_pin[g];

    buf_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_ovr[g].input_buffer_override_enable == (i_mask[g] && i_group_en)
      && !o_ovr[g].input_buffer_override_value)
      else $error("input buffer override gating wrong");
    no_takeover_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !o_ovr[g].pullup_override_enable && !o_ovr[g].direction_override_enable
      && !o_ovr[g].output_value_override_enable)
      else $error("pin function override raised");
    src_route_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $changed(i_pin[g]) |-> o_src[g] == i_pin[g])
      else $error("change source not following pin");
  end
endmodule
`default_nettype wire

// file: ppo_port_a.sv
// port a pin drive, pin sampling and change detection
`default_nettype none
module ppo_port_a #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_pin,
  input wire logic [W-1:0] i_dir,
  input wire logic [W-1:0] i_latch,
  output logic [W-1:0] o_sense,
  output logic [W-1:0] o_change,
  output logic [W-1:0] o_out,
  output logic [W-1:0] o_oe
);
  // ---------------------------------------------------------------
  // pin sense follows the pad level one cycle late
  // ---------------------------------------------------------------
  logic [W-1:0] sense_r;
  logic armed_r;

  // no reset level exists for pins, so start from zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sense_r <= ppo_pkg::RST_SENSE[W-1:0];
    end else begin
      sense_r <= i_pin;
    end
  end

  // pads may rest high in reset; the zero start must not look like an edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  // change is seen the cycle the pad differs from the last sample
  assign o_change = armed_r ? (i_pin ^ sense_r) : '0;
  assign o_sense = sense_r;

  // ---------------------------------------------------------------
  // drive: direction one puts the latch on the pad
  // ---------------------------------------------------------------
  assign o_oe = i_dir;
  assign o_out = i_latch;

  sense_track_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_sense == $past(i_pin))
    else $error("pin sense lags pad by wrong amount");
  drive_map_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (o_oe & o_out) == (i_dir & i_latch) && (o_oe == i_dir))
    else $error("pad drive does not match direction and latch");
endmodule
`default_nettype wire

// file: ppo_top.sv
// port pin override and port a register block behind an axi4-lite slave
`default_nettype none
module ppo_top #(
  parameter int ADDR_W = 8,
  parameter bit HAS_PORT_J = 1'b1,
  parameter int PA_W = 8,
  parameter int PH_W = 4,
  parameter int PJ_W = 7
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // axi4-lite write address
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [ADDR_W-1:0] i_axi_awaddr,
  // axi4-lite write data
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  // axi4-lite write response
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  output logic [1:0] o_axi_bresp,
  // axi4-lite read address
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [ADDR_W-1:0] i_axi_araddr,
  // axi4-lite read data
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  // port a pads
  input wire logic [PA_W-1:0] i_pa_pin,
  output logic [PA_W-1:0] o_pa_out,
  output logic [PA_W-1:0] o_pa_oe,
  // port h low half and port j change pins
  input wire logic [PH_W-1:0] i_ph_pin,
  input wire logic [PH_W-1:0] i_ph_mask,
  input wire logic [PJ_W-1:0] i_pj_pin,
  input wire logic [PJ_W-1:0] i_pj_mask,
  input wire logic i_group_en,
  output ppo_pkg::ppo_ovr_t [PH_W-1:0] o_ph_ovr,
  output ppo_pkg::ppo_ovr_t [PJ_W-1:0] o_pj_ovr,
  output logic [PH_W-1:0] o_ph_src,
  output logic [PJ_W-1:0] o_pj_src,
  // interrupt
  output logic o_irq
);
  // ---------------------------------------------------------------
  // address decode helper
  // ---------------------------------------------------------------
  // unaligned byte addresses never hit, so they fall to slverr
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
    logic [ADDR_W-1:0] byte_addr;
    byte_addr = ADDR_W'({idx, 2'b00});
    reg_hit = (addr == byte_addr);
  endfunction

  function automatic logic reg_known(input logic [ADDR_W-1:0] addr);
    reg_known = reg_hit(addr, ppo_pkg::IDX_SENSE) ||
                reg_hit(addr, ppo_pkg::IDX_DIR) ||
                reg_hit(addr, ppo_pkg::IDX_LATCH) ||
                reg_hit(addr, ppo_pkg::IDX_IRQ_STAT) ||
                reg_hit(addr, ppo_pkg::IDX_IRQ_MASK);
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [PA_W-1:0] dir_r;
  logic [PA_W-1:0] latch_r;
  logic [PA_W-1:0] irq_stat_r;
  logic [PA_W-1:0] irq_stat_nxt;
  logic [PA_W-1:0] irq_mask_r;
  logic [PA_W-1:0] pa_sense;
  logic [PA_W-1:0] pa_change;
  logic [PA_W-1:0] irq_clr;
  logic aw_held_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  ppo_pkg::ppo_wr_state_t wr_state_r;
  ppo_pkg::ppo_rd_state_t rd_state_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic lane0;
  logic wr_dir;
  logic wr_latch;
  logic wr_stat;
  logic wr_mask;

  // ---------------------------------------------------------------
  // write channel handshakes
  // ---------------------------------------------------------------
  // address and data are taken independently, then joined
  assign o_axi_awready = !aw_held_r && (wr_state_r == ppo_pkg::PPO_WR_IDLE);
  assign o_axi_wready = !w_held_r && (wr_state_r == ppo_pkg::PPO_WR_IDLE);
  assign aw_take = i_axi_awvalid && o_axi_awready;
  assign w_take = i_axi_wvalid && o_axi_wready;
  assign wr_fire = aw_held_r && w_held_r && (wr_state_r == ppo_pkg::PPO_WR_IDLE);
  assign lane0 = w_strb_r[ppo_pkg::STRB_LANE0];

  // per-register write strobes; only byte lane 0 carries data
  assign wr_dir = wr_fire && lane0 && reg_hit(aw_addr_r, ppo_pkg::IDX_DIR);
  assign wr_latch = wr_fire && lane0 && reg_hit(aw_addr_r, ppo_pkg::IDX_LATCH);
  assign wr_stat = wr_fire && lane0 && reg_hit(aw_addr_r, ppo_pkg::IDX_IRQ_STAT);
  assign wr_mask = wr_fire && lane0 && reg_hit(aw_addr_r, ppo_pkg::IDX_IRQ_MASK);

  // address holding register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= i_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  // data holding register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      w_data_r <= i_axi_wdata;
      w_strb_r <= i_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // write response state; one write in flight at a time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_state_r <= ppo_pkg::PPO_WR_IDLE;
      bresp_r <= ppo_pkg::RESP_OKAY;
    end else begin
      case (wr_state_r)
        ppo_pkg::PPO_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_r <= ppo_pkg::PPO_WR_RESP;
            bresp_r <= reg_known(aw_addr_r) ? ppo_pkg::RESP_OKAY
                                            : ppo_pkg::RESP_SLVERR;
          end
        end
        ppo_pkg::PPO_WR_RESP: begin
          if (i_axi_bready) begin
            wr_state_r <= ppo_pkg::PPO_WR_IDLE;
          end
        end
        default: begin
          wr_state_r <= ppo_pkg::PPO_WR_IDLE;
        end
      endcase
    end
  end

  assign o_axi_bvalid = (wr_state_r == ppo_pkg::PPO_WR_RESP);
  assign o_axi_bresp = bresp_r;

  // ---------------------------------------------------------------
  // port a control registers
  // ---------------------------------------------------------------
  // direction register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_r <= ppo_pkg::RST_DIR[PA_W-1:0];
    end else if (wr_dir) begin
      dir_r <= w_data_r[PA_W-1:0];
    end
  end

  // output latch register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latch_r <= ppo_pkg::RST_LATCH[PA_W-1:0];
    end else if (wr_latch) begin
      latch_r <= w_data_r[PA_W-1:0];
    end
  end

  // interrupt mask register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask_r <= ppo_pkg::RST_IRQ_MASK[PA_W-1:0];
    end else if (wr_mask) begin
      irq_mask_r <= w_data_r[PA_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // port a pins and change interrupt
  // ---------------------------------------------------------------
  ppo_port_a #(
    .W(PA_W)
  ) u_port_a (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_pa_pin),
    .i_dir(dir_r),
    .i_latch(latch_r),
    .o_sense(pa_sense),
    .o_change(pa_change),
    .o_out(o_pa_out),
    .o_oe(o_pa_oe)
  );

  // write-one-to-clear; a change in the same cycle keeps the bit set
  assign irq_clr = wr_stat ? w_data_r[PA_W-1:0] : '0;
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | pa_change;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= ppo_pkg::RST_IRQ_STAT[PA_W-1:0];
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign o_axi_arready = (rd_state_r == ppo_pkg::PPO_RD_IDLE);
  assign ar_take = i_axi_arvalid && o_axi_arready;

  // read data is captured at the address handshake and held
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= 32'h0000_0000;
      rresp_r <= ppo_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rresp_r <= ppo_pkg::RESP_OKAY;
      if (reg_hit(i_axi_araddr, ppo_pkg::IDX_SENSE)) begin
        rdata_r <= 32'(pa_sense);
      end else if (reg_hit(i_axi_araddr, ppo_pkg::IDX_DIR)) begin
        rdata_r <= 32'(dir_r);
      end else if (reg_hit(i_axi_araddr, ppo_pkg::IDX_LATCH)) begin
        rdata_r <= 32'(latch_r);
      end else if (reg_hit(i_axi_araddr, ppo_pkg::IDX_IRQ_STAT)) begin
        rdata_r <= 32'(irq_stat_r);
      end else if (reg_hit(i_axi_araddr, ppo_pkg::IDX_IRQ_MASK)) begin
        rdata_r <= 32'(irq_mask_r);
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= ppo_pkg::RESP_SLVERR;
      end
    end
  end

  // read response state; one read in flight at a time
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_state_r <= ppo_pkg::PPO_RD_IDLE;
    end else begin
      case (rd_state_r)
        ppo_pkg::PPO_RD_IDLE: begin
          if (ar_take) begin
            rd_state_r <= ppo_pkg::PPO_RD_RESP;
          end
        end
        ppo_pkg::PPO_RD_RESP: begin
          if (i_axi_rready) begin
            rd_state_r <= ppo_pkg::PPO_RD_IDLE;
          end
        end
        default: begin
          rd_state_r <= ppo_pkg::PPO_RD_IDLE;
        end
      endcase
    end
  end

  assign o_axi_rvalid = (rd_state_r == ppo_pkg::PPO_RD_RESP);
  assign o_axi_rdata = rdata_r;
  assign o_axi_rresp = rresp_r;

  // ---------------------------------------------------------------
  // change-only pins of port h and port j
  // ---------------------------------------------------------------
  ppo_change_override #(
    .W(PH_W)
  ) u_port_h (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ph_pin),
    .i_mask(i_ph_mask),
    .i_group_en(i_group_en),
    .o_ovr(o_ph_ovr),
    .o_src(o_ph_src)
  );

  // variants without port j tie its outputs quiet
  if (HAS_PORT_J) begin : g_port_j
    ppo_change_override #(
      .W(PJ_W)
    ) u_port_j (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_pj_pin),
      .i_mask(i_pj_mask),
      .i_group_en(i_group_en),
      .o_ovr(o_pj_ovr),
      .o_src(o_pj_src)
    );
  end else begin : g_no_port_j
    assign o_pj_ovr = '0;
    assign o_pj_src = '0;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  latch_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_latch |=> latch_r == $past(w_data_r[PA_W-1:0]) && o_axi_bvalid)
    else $error("latch write not applied");
  latch_keep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !wr_latch |=> $stable(latch_r))
    else $error("latch changed without a write");
  dir_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ar_take && reg_hit(i_axi_araddr, ppo_pkg::IDX_DIR)
    |=> o_axi_rvalid && o_axi_rdata == 32'($past(dir_r)))
    else $error("direction read back wrong");
  sense_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 ar_take && reg_hit(i_axi_araddr, ppo_pkg::IDX_SENSE)
    |=> o_axi_rdata == 32'($past(i_pa_pin, 2)))
    else $error("pin sense read wrong");
  port_j_gone_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !HAS_PORT_J |-> o_pj_src == '0 && o_pj_ovr == '0)
    else $error("absent port j is active");
  pad_drive_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_dir |=> o_pa_oe == $past(w_data_r[PA_W-1:0]) && o_pa_out == $past(latch_r))
    else $error("pad drive not following registers");
  bresp_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
    else $error("write response dropped early");
  irq_sticky_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    |pa_change |=> (irq_stat_r & $past(pa_change)) == $past(pa_change))
    else $error("pin change event lost");
endmodule
`default_nettype wire

// file: ppo_pins_model.sv
// board-side model of the port a pads
`default_nettype none
module ppo_pins_model (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_ext,
  output logic [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // pad resolution
  // ---------------------------------------------------------------
  // a driven pad shows the latch, an undriven one the board level
  // the board always drives its side, so no pad floats unknown
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule
`default_nettype wire

// file: port_pin_change_override_and_port_a_tb.sv
// self-checking bench for the port pin override and port a block
`default_nettype none
module port_pin_change_override_and_port_a_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_rst_n, awvalid, wvalid, bready, arvalid, rready, group_en;
  logic [7:0] awaddr, araddr, ext, d, l;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, ph_pin, ph_mask, ph_src;
  logic [6:0] pj_pin, pj_mask, pj_src, nj_src;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [7:0] pa_pin, pa_out, pa_oe;
  ppo_pkg::ppo_ovr_t [3:0] ph_ovr;
  ppo_pkg::ppo_ovr_t [6:0] pj_ovr, nj_ovr;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int errors, n_compared;

  // ---------------------------------------------------------------
  // clock, design and pads
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  ppo_top #(.HAS_PORT_J(1'b1)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
    .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .i_pa_pin(pa_pin), .o_pa_out(pa_out), .o_pa_oe(pa_oe), .i_ph_pin(ph_pin),
    .i_ph_mask(ph_mask), .i_pj_pin(pj_pin), .i_pj_mask(pj_mask), .i_group_en(group_en),
    .o_ph_ovr(ph_ovr), .o_pj_ovr(pj_ovr), .o_ph_src(ph_src), .o_pj_src(pj_src), .o_irq(irq));

  // variant without port j, bus idle, only its port j outputs are watched
  ppo_top #(.HAS_PORT_J(1'b0)) i_dut_nj (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_axi_awvalid(1'b0), .o_axi_awready(), .i_axi_awaddr(awaddr),
    .i_axi_wvalid(1'b0), .o_axi_wready(), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
    .o_axi_bvalid(), .i_axi_bready(bready), .o_axi_bresp(),
    .i_axi_arvalid(1'b0), .o_axi_arready(), .i_axi_araddr(araddr),
    .o_axi_rvalid(), .i_axi_rready(rready), .o_axi_rdata(), .o_axi_rresp(),
    .i_pa_pin(pa_pin), .o_pa_out(), .o_pa_oe(), .i_ph_pin(ph_pin),
    .i_ph_mask(ph_mask), .i_pj_pin(pj_pin), .i_pj_mask(pj_mask), .i_group_en(group_en),
    .o_ph_ovr(), .o_pj_ovr(nj_ovr), .o_ph_src(), .o_pj_src(nj_src), .o_irq());

  ppo_pins_model i_pins (.i_out(pa_out), .i_oe(pa_oe), .i_ext(ext), .o_pin(pa_pin));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ba(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

  // expected override bundles: only the input buffer enable may be set
  function automatic logic [34:0] ovr_exp(input logic [6:0] m, input logic g, input int n);
    logic [34:0] e;
    e = '0;
    for (int i = 0; i < n; i++) begin
      e[i*5 +: 5] = {3'b000, m[i] & g, 1'b0};
    end
    return e;
  endfunction

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s,
                    input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(r);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= dat;
    wstrb <= s;
    bready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
      if (bvalid) break;
    end
    // bready stays up, so a following write does not assign it twice in one step
  endtask

  // read: expected response and data noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] exp);
    logic ad;
    ad = 1'b0;
    rq.push_back(exp);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    forever begin
      @(posedge i_clk);
      if (!ad && arready) begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
      if (rvalid) break;
    end
    // rready stays up, so a following read does not assign it twice in one step
  endtask

  // monitor: oldest note against each answer as it is taken
  always @(posedge i_clk) begin
    if (rvalid && rready) begin
      if (rq.size() == 0) check(34'h0, 34'h3_ffff_ffff);
      else check({rresp, rdata}, rq.pop_front());
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) check(2'h0, 2'h3);
      else check(bresp, bq.pop_front());
    end
  end

  task automatic end_sim;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog: the whole run needs well under 200 cycles; the limit lies at 20000
  initial begin
    #100000;
    errors++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {i_rst_n, awvalid, wvalid, bready, arvalid, rready, group_en} = '0;
    {awaddr, araddr, ext, wdata, wstrb, ph_pin, ph_mask, pj_pin, pj_mask} = '0;
    void'($urandom(35));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    // reset values of every register except the irq status, and of the pads
    check({pa_oe, pa_out, 7'h00, irq}, 24'h00_0000);
    rd(ba(ppo_pkg::IDX_DIR), {ppo_pkg::RESP_OKAY, 32'h0000_0000});
    rd(ba(ppo_pkg::IDX_LATCH), {ppo_pkg::RESP_OKAY, 32'h0000_0000});
    rd(ba(ppo_pkg::IDX_SENSE), {ppo_pkg::RESP_OKAY, 32'h0000_0000});
    rd(ba(ppo_pkg::IDX_IRQ_MASK), {ppo_pkg::RESP_OKAY, 32'h0000_0000});
    // random direction, latch and board levels, back to back accesses
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      l = 8'($urandom);
      ext <= 8'($urandom);
      wr(ba(ppo_pkg::IDX_DIR), {24'h0000_00, d}, 4'h1, ppo_pkg::RESP_OKAY);
      wr(ba(ppo_pkg::IDX_LATCH), {24'hffff_ff, l}, 4'hf, ppo_pkg::RESP_OKAY);
      rd(ba(ppo_pkg::IDX_DIR), {ppo_pkg::RESP_OKAY, 24'h0000_00, d});
      rd(ba(ppo_pkg::IDX_LATCH), {ppo_pkg::RESP_OKAY, 24'h0000_00, l});
      check({pa_oe, pa_out}, {d, l});
      rd(ba(ppo_pkg::IDX_SENSE), {ppo_pkg::RESP_OKAY, 24'h0, (d & l) | (~d & ext)});
    end
    // lane 0 strobe off leaves the latch; sense writes change nothing
    wr(ba(ppo_pkg::IDX_LATCH), 32'h0000_005a, 4'he, ppo_pkg::RESP_OKAY);
    rd(ba(ppo_pkg::IDX_LATCH), {ppo_pkg::RESP_OKAY, 24'h0000_00, l});
    wr(ba(ppo_pkg::IDX_SENSE), 32'h0000_00ff, 4'h1, ppo_pkg::RESP_OKAY);
    rd(ba(ppo_pkg::IDX_SENSE), {ppo_pkg::RESP_OKAY, 24'h0, (d & l) | (~d & ext)});
    // unmapped and unaligned places answer with an error
    wr(8'h14, 32'h0000_00ff, 4'hf, ppo_pkg::RESP_SLVERR);
    rd(8'h14, {ppo_pkg::RESP_SLVERR, 32'h0000_0000});
    rd(8'h05, {ppo_pkg::RESP_SLVERR, 32'h0000_0000});
    // interrupt: raise from a pin change, mask, clear
    ext <= 8'h00;
    wr(ba(ppo_pkg::IDX_DIR), 32'h0000_0000, 4'h1, ppo_pkg::RESP_OKAY);
    repeat (3) @(posedge i_clk);
    wr(ba(ppo_pkg::IDX_IRQ_STAT), 32'h0000_00ff, 4'h1, ppo_pkg::RESP_OKAY);
    wr(ba(ppo_pkg::IDX_IRQ_MASK), 32'h0000_0001, 4'h1, ppo_pkg::RESP_OKAY);
    check(irq, 1'b0);
    ext <= 8'h01;
    repeat (3) @(posedge i_clk);
    check(irq, 1'b1);
    rd(ba(ppo_pkg::IDX_IRQ_STAT), {ppo_pkg::RESP_OKAY, 32'h0000_0001});
    wr(ba(ppo_pkg::IDX_IRQ_MASK), 32'h0000_0000, 4'h1, ppo_pkg::RESP_OKAY);
    check(irq, 1'b0);
    wr(ba(ppo_pkg::IDX_IRQ_STAT), 32'h0000_0001, 4'h1, ppo_pkg::RESP_OKAY);
    rd(ba(ppo_pkg::IDX_IRQ_STAT), {ppo_pkg::RESP_OKAY, 32'h0000_0000});
    wr(ba(ppo_pkg::IDX_IRQ_MASK), 32'h0000_0001, 4'h1, ppo_pkg::RESP_OKAY);
    check(irq, 1'b0);
    // change pins: sources follow pins, overrides follow mask and group
    for (int i = 0; i < 16; i++) begin
      ph_pin <= 4'($urandom);
      ph_mask <= 4'($urandom);
      pj_pin <= 7'($urandom);
      pj_mask <= 7'($urandom);
      group_en <= 1'(i);
      @(posedge i_clk);
      check({ph_src, pj_src}, {ph_pin, pj_pin});
      check(64'(ph_ovr), 64'(ovr_exp({3'b000, ph_mask}, group_en, 4)));
      check(64'(pj_ovr), 64'(ovr_exp(pj_mask, group_en, 7)));
      check(64'({nj_ovr, nj_src}), 64'h0000_0000_0000_0000);
    end
    end_sim();
  end
endmodule
`default_nettype wire
